// >>> rtl/cpu_decode_pkg.sv
// constants, register map and types for the opcode decoder and mask unit
package cpu_decode_pkg;

  // register byte addresses
  localparam logic [7:0] ADDR_INSTR  = 8'h00;
  localparam logic [7:0] ADDR_DECODE = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_ACK    = 8'h0c;

  // field positions of the instruction and status registers
  localparam int INSTR_OP_LSB  = 0;
  localparam int INSTR_ACC_LSB = 8;
  localparam int INSTR_FLG_LSB = 16;
  localparam int STATUS_SOUT_BIT = 8;
  localparam int STATUS_HALT_BIT = 9;
  localparam int STATUS_PEND_BIT = 10;
  localparam int STATUS_TGT_LSB  = 16;

  // fixed opcodes
  localparam logic [7:0] OP_IRQ_ON  = 8'hfb;
  localparam logic [7:0] OP_IRQ_OFF = 8'hf3;
  localparam logic [7:0] OP_MASK_WR = 8'h30;
  localparam logic [7:0] OP_MASK_RD = 8'h20;
  localparam logic [7:0] OP_IDLE    = 8'h00;
  localparam logic [7:0] OP_HALT    = 8'h76;

  // accumulator bits used by the mask write
  localparam int MASKWR_EN_BIT      = 3;
  localparam int MASKWR_CLR_HI_BIT  = 4;
  localparam int MASKWR_SOUT_EN_BIT = 6;
  localparam int MASKWR_SOUT_BIT    = 7;
  // mask read layout
  localparam int MASKRD_IE_BIT   = 3;
  localparam int MASKRD_PEND_LSB = 4;
  localparam int MASKRD_SIN_BIT  = 7;
  // flag byte layout
  localparam int FLG_S  = 7;
  localparam int FLG_Z  = 6;
  localparam int FLG_P  = 2;
  localparam int FLG_CY = 0;

  localparam logic [2:0] MEM_CODE   = 3'h6;
  localparam logic [2:0] MASK_RESET = 3'h7;
  localparam logic [2:0] HI_IDX     = 3'h4;
  localparam logic [2:0] SP_UP      = 3'h2;
  localparam logic [2:0] SP_DOWN    = 3'h6;
  localparam logic [2:0] SP_NONE    = 3'h0;

  // state counts per instruction kind
  localparam logic [4:0] T_SHORT   = 5'h04;
  localparam logic [4:0] T_COPY    = 5'h05;
  localparam logic [4:0] T_MEM     = 5'h07;
  localparam logic [4:0] T_PAIR    = 5'h0a;
  localparam logic [4:0] T_STACK   = 5'h0b;
  localparam logic [4:0] T_RET_NO  = 5'h05;
  localparam logic [4:0] T_RET_YES = 5'h0b;
  localparam logic [4:0] T_HALT    = 5'h05;

  typedef enum logic [3:0] {
    CLS_NONE = 4'h0, CLS_COPY = 4'h1, CLS_ALU = 4'h2, CLS_RET = 4'h3,
    CLS_LOAD = 4'h4, CLS_PUSH = 4'h5, CLS_POP = 4'h6, CLS_RESTART = 4'h7,
    CLS_IRQ_ON = 4'h8, CLS_IRQ_OFF = 4'h9, CLS_MASK_WR = 4'ha,
    CLS_MASK_RD = 4'hb, CLS_HALT = 4'hc, CLS_IDLE = 4'hd
  } instr_class_type;

  typedef struct packed {
    logic [2:0]      sp_adj;
    logic            taken;
    logic [1:0]      pair;
    logic [2:0]      alu;
    logic [2:0]      src;
    logic [2:0]      dst;
    logic [4:0]      states;
    instr_class_type cls;
  } decode_type;

  typedef enum logic [1:0] {
    ST_RUN  = 2'b01,
    ST_HALT = 2'b10
  } run_state_type;

endpackage : cpu_decode_pkg

// >>> rtl/cpu_interrupt_mask_and_opcode_decode.sv
// opcode decoder with interrupt mask, enable and serial latch control
`timescale 1ns/100ps
`default_nettype none

module cpu_interrupt_mask_and_opcode_decode
  import cpu_decode_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  input  wire logic [2:0]  restart_in,
  input  wire logic        serial_in_line,
  output var  logic        serial_out_latch,
  output var  logic        irq_enabled,
  output var  logic        halted,
  output var  logic        irq_taken,
  output var  logic [2:0]  irq_which
);

  // condition select: nz z nc c po pe p m
  function automatic logic cond_met(input logic [2:0] ccc,
                                    input logic [7:0] flg);
    logic f;
    f = 1'b0;
    unique case (ccc[2:1])
      2'b00: f = flg[FLG_Z];
      2'b01: f = flg[FLG_CY];
      2'b10: f = flg[FLG_P];
      2'b11: f = flg[FLG_S];
    endcase
    return f == ccc[0];
  endfunction : cond_met

  function automatic logic is_mem(input logic [2:0] field);
    return field == MEM_CODE;
  endfunction : is_mem

  logic [3:0]    sync1_q, sync1_d, sync2_q, sync2_d;
  logic          hi_prev_q, hi_prev_d;
  logic [2:0]    mask_q, mask_d;
  logic          hi_req_q, hi_req_d;
  logic          ie_q, ie_d;
  logic          on_pend_q, on_pend_d;
  logic          sout_q, sout_d;
  run_state_type state_q, state_d;
  logic [23:0]   instr_q, instr_d;
  decode_type    dec_q, dec_d;
  logic [31:0]   rdata_q, rdata_d;
  logic          take_q, take_d;
  logic [2:0]    which_q, which_d;

  logic        wr_acc, rd_setup, mapped, exec, take, hi_edge;
  logic [7:0]  op, acc, flg, mask_rd_val;
  logic [2:0]  pend, live, pick;
  logic [15:0] tgt;

  // apb decode; no wait states so pready stays high
  assign mapped   = paddr == ADDR_INSTR || paddr == ADDR_DECODE ||
                    paddr == ADDR_STATUS || paddr == ADDR_ACK;
  assign pready   = 1'b1;
  assign pslverr  = psel && penable && !mapped;
  assign wr_acc   = psel && penable && pwrite && mapped;
  assign rd_setup = psel && !penable && !pwrite;
  assign op  = pwdata[INSTR_OP_LSB +: 8];
  assign acc = pwdata[INSTR_ACC_LSB +: 8];
  assign flg = pwdata[INSTR_FLG_LSB +: 8];
  // a halted core ignores instruction writes
  assign exec = wr_acc && paddr == ADDR_INSTR && state_q == ST_RUN;

  // pending requests; the low two inputs are level sensed
  assign pend = {hi_req_q, sync2_q[1:0]};
  assign live = pend & ~mask_q;
  assign take = ie_q && (live != 3'h0) && !exec;
  assign pick = live[2] ? 3'h4 : (live[1] ? 3'h2 : 3'h1);
  assign mask_rd_val = {sync2_q[3], pend, ie_q, mask_q};
  assign tgt = {10'h000, instr_q[INSTR_OP_LSB + 3 +: 3], 3'h0};
  assign hi_edge = sync2_q[2] && !hi_prev_q;

  // opcode decode from the byte being written; returns also use the flag byte
  always_comb
  begin
    dec_d = dec_q;
    if (exec)
    begin
      dec_d = '0;
      dec_d.cls    = CLS_NONE;
      dec_d.dst    = op[5:3];
      dec_d.src    = op[2:0];
      dec_d.alu    = op[5:3];
      dec_d.pair   = op[5:4];
      dec_d.sp_adj = SP_NONE;
      if (op == OP_HALT)
      begin
        dec_d.cls    = CLS_HALT;
        dec_d.states = T_HALT;
      end
      else if (op == OP_IDLE)
      begin
        dec_d.cls    = CLS_IDLE;
        dec_d.states = T_SHORT;
      end
      else if (op == OP_IRQ_ON || op == OP_IRQ_OFF)
      begin
        dec_d.cls    = (op == OP_IRQ_ON) ? CLS_IRQ_ON : CLS_IRQ_OFF;
        dec_d.states = T_SHORT;
      end
      else if (op == OP_MASK_WR || op == OP_MASK_RD)
      begin
        dec_d.cls    = (op == OP_MASK_WR) ? CLS_MASK_WR : CLS_MASK_RD;
        dec_d.states = T_SHORT;
      end
      else if (op[7:6] == 2'b01)
      begin
        dec_d.cls    = CLS_COPY;
        dec_d.states = (is_mem(op[5:3]) || is_mem(op[2:0])) ?
                       T_MEM : T_COPY;
      end
      else if (op[7:6] == 2'b10)
      begin
        dec_d.cls    = CLS_ALU;
        dec_d.states = is_mem(op[2:0]) ? T_MEM : T_SHORT;
      end
      else if (op[7:6] == 2'b00 && op[3:0] == 4'h1)
      begin
        dec_d.cls    = CLS_LOAD;
        dec_d.states = T_PAIR;
      end
      else if (op[7:6] == 2'b11 && op[2:0] == 3'h0)
      begin
        dec_d.cls    = CLS_RET;
        dec_d.taken  = cond_met(op[5:3], flg);
        dec_d.states = dec_d.taken ? T_RET_YES : T_RET_NO;
        dec_d.sp_adj = dec_d.taken ? SP_UP : SP_NONE;
      end
      else if (op[7:6] == 2'b11 && op[3:0] == 4'h5)
      begin
        dec_d.cls    = CLS_PUSH;
        dec_d.states = T_STACK;
        dec_d.sp_adj = SP_DOWN;
      end
      else if (op[7:6] == 2'b11 && op[3:0] == 4'h1)
      begin
        dec_d.cls    = CLS_POP;
        dec_d.states = T_PAIR;
        dec_d.sp_adj = SP_UP;
      end
      else if (op[7:6] == 2'b11 && op[2:0] == 3'h7)
      begin
        dec_d.cls    = CLS_RESTART;
        dec_d.states = T_STACK;
        dec_d.sp_adj = SP_DOWN;
      end
    end
  end

  // interrupt control, masks, serial latch and run state
  always_comb
  begin
    sync1_d   = {serial_in_line, restart_in};
    sync2_d   = sync1_q;
    hi_prev_d = sync2_q[2];
    mask_d    = mask_q;
    hi_req_d  = hi_req_q;
    ie_d      = ie_q;
    on_pend_d = on_pend_q;
    sout_d    = sout_q;
    state_d   = state_q;
    instr_d   = instr_q;
    take_d    = 1'b0;
    which_d   = which_q;
    if (exec)
    begin
      instr_d = pwdata[23:0];
      // ie rises once the next instruction ends, even a second enable, unless that instruction is a disable
      if (on_pend_q)
      begin
        ie_d      = 1'b1;
        on_pend_d = 1'b0;
      end
      unique case (op)
        OP_IRQ_ON:  on_pend_d = 1'b1;
        OP_IRQ_OFF:
        begin
          ie_d      = 1'b0;
          on_pend_d = 1'b0;
        end
        OP_MASK_WR:
        begin
          if (acc[MASKWR_EN_BIT])
            mask_d = acc[2:0];
          if (acc[MASKWR_CLR_HI_BIT])
            hi_req_d = 1'b0;
          if (acc[MASKWR_SOUT_EN_BIT])
            sout_d = acc[MASKWR_SOUT_BIT];
        end
        OP_MASK_RD: instr_d[INSTR_ACC_LSB +: 8] = mask_rd_val;
        OP_HALT:    state_d = ST_HALT;
        default:    ;
      endcase
    end
    else if (wr_acc && paddr == ADDR_ACK && pwdata[2])
      hi_req_d = 1'b0;
    // recognition: ie drops and the halt is left
    if (take)
    begin
      ie_d      = 1'b0;
      on_pend_d = 1'b0;
      state_d   = ST_RUN;
      take_d    = 1'b1;
      which_d   = pick;
      if (pick == HI_IDX)
        hi_req_d = 1'b0;
    end
    // a fresh edge beats any clear in the same cycle
    if (hi_edge)
      hi_req_d = 1'b1;
  end

  // read data is staged in setup so it is stable in the access cycle
  always_comb
  begin
    rdata_d = rdata_q;
    if (rd_setup)
    begin
      unique case (paddr)
        ADDR_INSTR:  rdata_d = {8'h00, instr_q};
        ADDR_DECODE: rdata_d = {8'h00, dec_q};
        ADDR_STATUS: rdata_d = {tgt, 5'h00, on_pend_q,
                                state_q == ST_HALT, sout_q, mask_rd_val};
        default:     rdata_d = 32'h0000_0000;
      endcase
    end
  end

  // all state registers; reset values are constants only
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync1_q   <= 4'h0;
      sync2_q   <= 4'h0;
      hi_prev_q <= 1'b0;
      mask_q    <= MASK_RESET;
      hi_req_q  <= 1'b0;
      ie_q      <= 1'b0;
      on_pend_q <= 1'b0;
      sout_q    <= 1'b0;
      state_q   <= ST_RUN;
      instr_q   <= 24'h00_0000;
      dec_q     <= '0;
      rdata_q   <= 32'h0000_0000;
      take_q    <= 1'b0;
      which_q   <= 3'h0;
    end
    else
    begin
      sync1_q   <= sync1_d;
      sync2_q   <= sync2_d;
      hi_prev_q <= hi_prev_d;
      mask_q    <= mask_d;
      hi_req_q  <= hi_req_d;
      ie_q      <= ie_d;
      on_pend_q <= on_pend_d;
      sout_q    <= sout_d;
      state_q   <= state_d;
      instr_q   <= instr_d;
      dec_q     <= dec_d;
      rdata_q   <= rdata_d;
      take_q    <= take_d;
      which_q   <= which_d;
    end
  end

  assign prdata           = rdata_q;
  assign serial_out_latch = sout_q;
  assign irq_enabled      = ie_q;
  assign halted           = state_q == ST_HALT;
  assign irq_taken        = take_q;
  assign irq_which        = which_q;

  // checks
  sequence s_exec_op(logic [7:0] o);
    exec && op == o;
  endsequence

  property p_on_delay;
    @(posedge clk) disable iff (!rst_n)
    s_exec_op(OP_IRQ_ON) ##0 !on_pend_q ##1 !take
      |-> !ie_q || $past(ie_q);
  endproperty
  a_on_delay: assert property (p_on_delay)
    else $error("enable took effect without waiting");

  property p_off_now;
    @(posedge clk) disable iff (!rst_n)
    s_exec_op(OP_IRQ_OFF) |=> !ie_q && !on_pend_q;
  endproperty
  a_off_now: assert property (p_off_now)
    else $error("disable did not act at once");

  property p_mask_wr;
    @(posedge clk) disable iff (!rst_n)
    s_exec_op(OP_MASK_WR) |=>
      mask_q == ($past(acc[MASKWR_EN_BIT]) ? $past(acc[2:0])
                                           : $past(mask_q));
  endproperty
  a_mask_wr: assert property (p_mask_wr)
    else $error("mask write result wrong");

  property p_mask_block;
    @(posedge clk) disable iff (!rst_n)
    irq_taken |-> (irq_which & $past(mask_q)) == 3'h0;
  endproperty
  a_mask_block: assert property (p_mask_block)
    else $error("masked input was taken");

  property p_sout;
    @(posedge clk) disable iff (!rst_n)
    s_exec_op(OP_MASK_WR) |=>
      sout_q == ($past(acc[MASKWR_SOUT_EN_BIT]) ? $past(acc[MASKWR_SOUT_BIT])
                                                : $past(sout_q));
  endproperty
  a_sout: assert property (p_sout)
    else $error("serial latch update wrong");

  property p_clr_hi;
    @(posedge clk) disable iff (!rst_n)
    s_exec_op(OP_MASK_WR) ##0 acc[MASKWR_CLR_HI_BIT] ##0 !hi_edge
      |=> !hi_req_q;
  endproperty
  a_clr_hi: assert property (p_clr_hi)
    else $error("high request not cleared");

  property p_halt_hold;
    @(posedge clk) disable iff (!rst_n)
    halted && !take ##1 wr_acc && paddr == ADDR_INSTR
      |=> $stable(instr_q) && $stable(dec_q);
  endproperty
  a_halt_hold: assert property (p_halt_hold)
    else $error("halted core executed");

  property p_copy_states;
    @(posedge clk) disable iff (!rst_n)
    exec && op[7:6] == 2'b01 && op != OP_HALT |=>
      dec_q.states == ((is_mem($past(op[5:3])) || is_mem($past(op[2:0])))
                       ? T_MEM : T_COPY);
  endproperty
  a_copy_states: assert property (p_copy_states)
    else $error("copy state count wrong");

  property p_ret;
    @(posedge clk) disable iff (!rst_n)
    exec && op[7:6] == 2'b11 && op[2:0] == 3'h0 |=>
      dec_q.taken == cond_met($past(op[5:3]), $past(flg)) &&
      dec_q.states == (dec_q.taken ? T_RET_YES : T_RET_NO);
  endproperty
  a_ret: assert property (p_ret)
    else $error("conditional return decode wrong");

  property p_edge_hold;
    @(posedge clk) disable iff (!rst_n)
    hi_edge |=> hi_req_q;
  endproperty
  a_edge_hold: assert property (p_edge_hold)
    else $error("high input edge lost");

endmodule : cpu_interrupt_mask_and_opcode_decode

`default_nettype wire

// >>> tb/pin_partner.sv
// pin-level model of the restart sources and serial input line
`timescale 1ns/100ps
`default_nettype none

module pin_partner
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [2:0] want_req,
  input  wire logic       want_sin,
  output var  logic [2:0] restart_in,
  output var  logic       serial_in_line
);
  // pins move just after an edge, as a synchronous source would
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      restart_in     <= 3'h0;
      serial_in_line <= 1'b0;
    end
    else
    begin
      restart_in     <= want_req;
      serial_in_line <= want_sin;
    end
  end
endmodule : pin_partner
`default_nettype wire

// >>> tb/cpu_interrupt_mask_and_opcode_decode_test.sv
// self-checking bench for the opcode decoder and interrupt mask unit
`timescale 1ns/100ps
`default_nettype none

module cpu_interrupt_mask_and_opcode_decode_test
  import cpu_decode_pkg::*;
;
  logic        clk      = 1'b0;
  logic        rst_n    = 1'b0;
  logic        psel     = 1'b0;
  logic        penable  = 1'b0;
  logic        pwrite   = 1'b0;
  logic [7:0]  paddr    = 8'h00;
  logic [31:0] pwdata   = 32'h0;
  logic [2:0]  want_req = 3'h0;
  logic        want_sin = 1'b0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [2:0]  restart_in;
  logic        serial_in_line;
  logic        serial_out_latch;
  logic        irq_enabled;
  logic        halted;
  logic        irq_taken;
  logic [2:0]  irq_which;
  logic [31:0] rd;
  logic        err;
  int          bad_count = 0;
  int          n_tests   = 0;
  int          took      = 0;

  always #2 clk = ~clk;

  cpu_interrupt_mask_and_opcode_decode u_cpu_interrupt_mask_and_opcode_decode
  (
    .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .restart_in(restart_in),
    .serial_in_line(serial_in_line), .serial_out_latch(serial_out_latch),
    .irq_enabled(irq_enabled), .halted(halted), .irq_taken(irq_taken),
    .irq_which(irq_which)
  );

  pin_partner u_pin_partner
  (
    .clk(clk), .rst_n(rst_n), .want_req(want_req), .want_sin(want_sin),
    .restart_in(restart_in), .serial_in_line(serial_in_line)
  );

  // the take flag is a one-cycle pulse, so count it as it passes
  always @(posedge clk)
    if (irq_taken === 1'b1)
      took <= took + 1;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
  begin
    n_tests++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  end
  endtask : check

  // one apb transfer; ends at a falling edge so state updates have landed
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
  begin
    @(posedge clk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    // only the watchdog ends a wait that never sees pready
    do
      @(posedge clk);
    while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(negedge clk);
  end
  endtask : apb

  task automatic exec(input logic [7:0] op, input logic [7:0] acc,
                      input logic [7:0] flg);
  begin
    apb(1'b1, ADDR_INSTR, {8'h00, flg, acc, op});
  end
  endtask : exec

  // execute, then compare class, states, return flag and stack adjust
  task automatic dec(input logic [7:0] op, input logic [7:0] flg,
                     input logic [3:0] cls, input logic [4:0] st,
                     input logic [2:0] sp, input logic tk);
  begin
    exec(op, 8'h00, flg);
    apb(1'b0, ADDR_DECODE, 32'h0);
    check(rd & 32'h00f001ff, {8'h00, sp, tk, 11'h000, st, cls});
  end
  endtask : dec

  task automatic results;
  begin
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  end
  endtask : results

  // watchdog: the whole sequence needs well under a thousand transfers
  initial
  begin
    repeat (20000) @(posedge clk);
    bad_count++;
    results();
  end

  initial
  begin
    int i;
    logic tk;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    apb(1'b0, ADDR_STATUS, 32'h0);
    check({21'h0, rd[10:0]}, 32'h007);
    // mask write: clear masks, latch a one
    exec(OP_MASK_WR, 8'hc8, 8'h00);
    check({31'h0, serial_out_latch}, 32'h1);
    apb(1'b0, ADDR_STATUS, 32'h0);
    check({23'h0, rd[8:0]}, 32'h100);
    exec(OP_MASK_WR, 8'h05, 8'h00);
    apb(1'b0, ADDR_STATUS, 32'h0);
    check({23'h0, rd[8:0]}, 32'h100);
    exec(OP_MASK_WR, 8'h40, 8'h00);
    check({31'h0, serial_out_latch}, 32'h0);
    // enable waits one instruction, then mask read shows ie and the serial input
    want_sin <= 1'b1;
    dec(OP_IRQ_ON, 8'h00, 4'h8, 5'h04, 3'h0, 1'b0);
    check({31'h0, irq_enabled}, 32'h0);
    dec(OP_IDLE, 8'h00, 4'hd, 5'h04, 3'h0, 1'b0);
    check({31'h0, irq_enabled}, 32'h1);
    exec(OP_MASK_RD, 8'h00, 8'h00);
    apb(1'b0, ADDR_INSTR, 32'h0);
    check({24'h0, rd[15:8]}, 32'h88);
    // unmasked mid input is taken and turns the system off
    want_req <= 3'h2;
    repeat (8) @(posedge clk);
    check(took, 32'h1);
    check({29'h0, irq_which}, 32'h2);
    check({31'h0, irq_enabled}, 32'h0);
    want_req <= 3'h0;
    // masked mid input is ignored
    exec(OP_MASK_WR, 8'h0a, 8'h00);
    exec(OP_IRQ_ON, 8'h00, 8'h00);
    exec(OP_IRQ_ON, 8'h00, 8'h00);
    check({31'h0, irq_enabled}, 32'h1);
    want_req <= 3'h2;
    repeat (8) @(posedge clk);
    check(took, 32'h1);
    want_req <= 3'h0;
    dec(OP_IRQ_OFF, 8'h00, 4'h9, 5'h04, 3'h0, 1'b0);
    check({31'h0, irq_enabled}, 32'h0);
    // short pulse on the high input stays pending until cleared
    want_req <= 3'h4;
    repeat (3) @(posedge clk);
    want_req <= 3'h0;
    repeat (6) @(posedge clk);
    apb(1'b0, ADDR_STATUS, 32'h0);
    check({24'h0, rd[7:0]}, 32'hc2);
    exec(OP_MASK_WR, 8'h1e, 8'h00);
    apb(1'b0, ADDR_STATUS, 32'h0);
    check({24'h0, rd[7:0]}, 32'h86);
    // a second pulse waits, then the clear register drops it
    want_req <= 3'h4;
    repeat (3) @(posedge clk);
    want_req <= 3'h0;
    repeat (6) @(posedge clk);
    apb(1'b0, ADDR_STATUS, 32'h0);
    check({24'h0, rd[7:0]}, 32'hc6);
    apb(1'b1, ADDR_ACK, 32'h0000_0004);
    apb(1'b0, ADDR_STATUS, 32'h0);
    check({24'h0, rd[7:0]}, 32'h86);
    // unmasked high edge is taken and its request dropped
    exec(OP_MASK_WR, 8'hc8, 8'h00);
    exec(OP_IRQ_ON, 8'h00, 8'h00);
    exec(OP_IDLE, 8'h00, 8'h00);
    want_req <= 3'h4;
    repeat (3) @(posedge clk);
    want_req <= 3'h0;
    repeat (6) @(posedge clk);
    check(took, 32'h2);
    check({29'h0, irq_which}, 32'h4);
    apb(1'b0, ADDR_STATUS, 32'h0);
    check({23'h0, rd[8:0]}, 32'h180);
    // decode table
    dec(8'h41, 8'h00, 4'h1, 5'h05, 3'h0, 1'b0);
    dec(8'h46, 8'h00, 4'h1, 5'h07, 3'h0, 1'b0);
    dec(8'h70, 8'h00, 4'h1, 5'h07, 3'h0, 1'b0);
    dec(8'h86, 8'h00, 4'h2, 5'h07, 3'h0, 1'b0);
    for (i = 0; i < 8; i++)
    begin
      dec({2'b10, i[2:0], 3'h1}, 8'h00, 4'h2, 5'h04, 3'h0, 1'b0);
      check({29'h0, rd[17:15]}, {29'h0, i[2:0]});
    end
    // all flags clear, then all set: taken flips with the low code bit
    for (i = 0; i < 16; i++)
    begin
      tk = i[0] ^ ~i[3];
      dec({2'b11, i[2:0], 3'h0}, i[3] ? 8'hc5 : 8'h00, 4'h3,
          tk ? 5'h0b : 5'h05, tk ? 3'h2 : 3'h0, tk);
    end
    for (i = 0; i < 4; i++)
    begin
      dec({2'b00, i[1:0], 4'h1}, 8'h00, 4'h4, 5'h0a, 3'h0, 1'b0);
      check({30'h0, rd[19:18]}, {30'h0, i[1:0]});
      dec({2'b11, i[1:0], 4'h5}, 8'h00, 4'h5, 5'h0b, 3'h6, 1'b0);
      check({30'h0, rd[19:18]}, {30'h0, i[1:0]});
      dec({2'b11, i[1:0], 4'h1}, 8'h00, 4'h6, 5'h0a, 3'h2, 1'b0);
      check({30'h0, rd[19:18]}, {30'h0, i[1:0]});
    end
    dec(8'hef, 8'h00, 4'h7, 5'h0b, 3'h6, 1'b0);
    apb(1'b0, ADDR_STATUS, 32'h0);
    check({16'h0, rd[31:16]}, 32'h28);
    // unmapped address is refused
    apb(1'b0, 8'h10, 32'h0);
    check({31'h0, err}, 32'h1);
    check(rd, 32'h0);
    // halt stops further instructions
    dec(OP_HALT, 8'h00, 4'hc, 5'h05, 3'h0, 1'b0);
    check({31'h0, halted}, 32'h1);
    exec(OP_IDLE, 8'h00, 8'h00);
    apb(1'b0, ADDR_INSTR, 32'h0);
    check({24'h0, rd[7:0]}, 32'h76);
    // reset in mid-run sets masks, clears the latch and leaves the halt
    want_sin <= 1'b0;
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    apb(1'b0, ADDR_STATUS, 32'h0);
    check(rd, 32'h0000_0007);
    check({31'h0, serial_out_latch}, 32'h0);
    results();
  end
endmodule : cpu_interrupt_mask_and_opcode_decode_test
`default_nettype wire
